// file: design/swc_pkg.sv
/*
  Constants for the streaming write command interpreter: register map,
  field positions, reset values, opcodes, state codes and timing counts.
  Assumes a 100 MHz system clock and a 32-bit APB register bus.
*/
package swc_pkg;

  // ==========================================================
  // Register map (byte addresses)
  localparam int          APB_AW        = 12;
  localparam logic [11:0] OFS_OPTIONS   = 12'h000;
  localparam logic [11:0] OFS_TL_MULT   = 12'h004;
  localparam logic [11:0] OFS_COUNT     = 12'h008;
  localparam logic [11:0] OFS_ADDR_CUR  = 12'h00C;
  localparam logic [11:0] OFS_ADDR_PREV = 12'h010;
  localparam logic [11:0] OFS_COMMAND   = 12'h014;
  localparam logic [11:0] OFS_CAUSE     = 12'h018;
  localparam logic [11:0] OFS_ENDING    = 12'h01C;
  localparam logic [11:0] OFS_TIME_UNIT = 12'h020;
  localparam logic [11:0] OFS_STRM_CFG  = 12'h024;
  localparam logic [11:0] OFS_DEV_CTL   = 12'h028;
  localparam logic [11:0] OFS_REMAIN    = 12'h02C;

  // ==========================================================
  // Opcodes
  localparam logic [7:0] OPC_STREAM_PIO = 8'h3B;
  localparam logic [7:0] OPC_STREAM_DMA = 8'h3A;

  // ==========================================================
  // Field positions
  localparam int OPT_URGENT = 7;
  localparam int OPT_CONT   = 6;
  localparam int OPT_FLUSH  = 5;
  localparam int OPT_RESUME = 4;
  localparam int OPT_SEL_HI = 2;
  localparam int OPT_SEL_LO = 0;
  localparam int ERR_CRC    = 7;
  localparam int ERR_NOID   = 4;
  localparam int ERR_ABORT  = 2;
  localparam int ERR_TLX    = 0;
  localparam int STS_BUSY   = 7;
  localparam int STS_RDY    = 6;
  localparam int STS_STREAM = 5;
  localparam int STS_DEFER  = 4;
  localparam int STS_XREQ   = 3;
  localparam int STS_FAIL   = 0;
  localparam int CFG_SEL_LO = 8;
  localparam int CFG_SEL_HI = 10;
  localparam int CTL_HISEL  = 7;

  // ==========================================================
  // Error kinds from the media path
  localparam logic [1:0] KIND_CRC   = 2'h0;
  localparam logic [1:0] KIND_NOID  = 2'h1;
  localparam logic [1:0] KIND_ABORT = 2'h2;

  // ==========================================================
  // Reset values and counts
  localparam logic [31:0] RST_TIME_UNIT = 32'h0000_0001;
  localparam logic [39:0] RST_MIN_LIMIT = 40'h00_0000_03E8;
  localparam logic [16:0] FULL_COUNT    = 17'h1_0000;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int US_NS         = 1000;
  localparam int US_CYCLES     = US_NS / CLK_PERIOD_NS;

  // ==========================================================
  // Command states
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_XFER  = 4'b0010,
    ST_FLUSH = 4'b0100,
    ST_END   = 4'b1000
  } swc_state_e;

endpackage

// file: design/swc_stream_write.sv
/*
  Streaming write command interpreter: task file registers over APB,
  option decoding, completion time limit, sector sequencing, ending
  status, error cause and failing address report.
  Assumes a media engine that answers each sector request with a
  one-cycle done pulse and each flush request with a done pulse.
*/
// Summary of operation
// - Urgent option is passed to media and the time limit still applies.
// - Continue-on-error keeps the command running through sector errors.
// - Continue: errors end as stream error without failure, cause logged.
// - Continue: timeout stops as stream error, no failure, logged.
// - Continue: all requested sectors are attempted until the time limit expires.
// - Flush option drains the stream to media after the last sector, unless an error stop or timeout ends the command.
// - Resume option starts at the stream's last reported error address.
// - Three-bit stream selector picks the per-stream settings used.
// - Time limit equals multiplier byte times identify time unit, in us.
// - Zero multiplier falls back to the stream's configured default.
// - No usable default means no time limit for the command.
// - Elapsed time runs from command write to completion pulse.
// - Limits shorter than the minimum are raised to the minimum.
// - A zero sector count means 65536 sectors.
// - Start address is previous bytes over current bytes, 48 bits.
// - First failing address reads back, halves chosen by high select.
// - Timeout sets bit 0 of the failure cause register.
// - Opcode 3Bh starts the programmed-transfer streaming write.
// - Opcode 3Ah starts the same command using DMA transfer.
`timescale 1ns/100ps

module swc_stream_write
  import swc_pkg::*;
#(
  parameter logic [39:0] MIN_LIMIT_US = RST_MIN_LIMIT,
  parameter logic [31:0] TIME_UNIT_US = RST_TIME_UNIT
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  output logic             o_sector_req,
  output logic      [47:0] o_sector_lba,
  output logic             o_dma_mode,
  output logic             o_urgent,
  output logic      [2:0]  o_stream_sel,
  input  wire logic        i_sector_done,
  input  wire logic        i_sector_err,
  input  wire logic [1:0]  i_err_kind,
  output logic             o_flush_req,
  input  wire logic        i_flush_done,
  output logic             o_transfer_request,
  output logic             o_busy,
  output logic             o_cmd_done
);

  localparam int TICK_W = $clog2(US_CYCLES);

  // ==========================================================
  // Helpers
  function automatic logic [39:0] calc_limit(input logic [7:0]  mult,
                                             input logic [31:0] unit);
    logic [39:0] prod;
    prod = 40'(mult) * 40'(unit);
    return (prod < MIN_LIMIT_US) ? MIN_LIMIT_US : prod;
  endfunction

  function automatic logic is_mapped(input logic [11:0] a);
    return (a <= OFS_REMAIN) && (a[1:0] == 2'h0);
  endfunction

  // ==========================================================
  // Declarations
  swc_state_e  state_q;
  logic [7:0]  opt_q;
  logic [7:0]  tl_mult_q;
  logic [15:0] count_q;
  logic [23:0] addr_cur_q;
  logic [23:0] addr_prev_q;
  logic [31:0] time_unit_q;
  logic        hi_sel_q;
  logic [7:0]  cfg_dflt_q  [8];
  logic [7:0]  cfg_valid_q;
  logic [47:0] last_err_q  [8];
  logic [47:0] lba_q;
  logic [16:0] remain_q;
  logic        dma_q;
  logic [7:0]  cmd_opt_q;
  logic [TICK_W-1:0] tick_q;
  logic [39:0] elapsed_q;
  logic [39:0] lim_q;
  logic        lim_en_q;
  logic [7:0]  cause_q;
  logic        strm_err_q;
  logic        fail_q;
  logic        err_seen_q;
  logic [47:0] fail_lba_q;
  logic [7:0]  ending;
  logic        wr;
  logic        cmd_wr;
  logic        start;
  logic        bad_cmd;
  logic [2:0]  sel_d;
  logic [7:0]  eff_mult;
  logic        lim_en_d;
  logic        active;
  logic        timeout;
  logic        sec_ev;
  logic        sec_err;
  logic        fatal_err;
  logic        cont;

  // ==========================================================
  // Bus decode
  assign wr       = i_psel & i_penable & i_pwrite;
  assign cmd_wr   = wr & (i_paddr == OFS_COMMAND);
  assign start    = cmd_wr & (state_q == ST_IDLE) &
                    ((i_pwdata[7:0] == OPC_STREAM_PIO) |
                     (i_pwdata[7:0] == OPC_STREAM_DMA));
  assign bad_cmd  = cmd_wr & (state_q == ST_IDLE) & ~start;
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel & i_penable & (~is_mapped(i_paddr) |
                     (cmd_wr & (state_q != ST_IDLE)));

  always_comb begin
    o_prdata = 32'h0000_0000;
    if (i_psel && !i_pwrite) begin
      case (i_paddr)
        OFS_ADDR_CUR:  o_prdata = {8'h00, hi_sel_q ? fail_lba_q[47:24]
                                  : fail_lba_q[23:0]};
        OFS_CAUSE:     o_prdata = {24'h0, cause_q};
        OFS_ENDING:    o_prdata = {24'h0, ending};
        OFS_TIME_UNIT: o_prdata = time_unit_q;
        OFS_DEV_CTL:   o_prdata = 32'(hi_sel_q) << CTL_HISEL;
        OFS_REMAIN:    o_prdata = {15'h0, remain_q};
        default:       o_prdata = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // Host-written parameter registers
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      opt_q       <= 8'h00;
      tl_mult_q   <= 8'h00;
      count_q     <= 16'h0000;
      addr_cur_q  <= 24'h00_0000;
      addr_prev_q <= 24'h00_0000;
      time_unit_q <= TIME_UNIT_US;
      hi_sel_q    <= 1'b0;
    end else if (wr) begin
      case (i_paddr)
        OFS_OPTIONS:   opt_q       <= i_pwdata[7:0];
        OFS_TL_MULT:   tl_mult_q   <= i_pwdata[7:0];
        OFS_COUNT:     count_q     <= i_pwdata[15:0];
        OFS_ADDR_CUR:  addr_cur_q  <= i_pwdata[23:0];
        OFS_ADDR_PREV: addr_prev_q <= i_pwdata[23:0];
        OFS_TIME_UNIT: time_unit_q <= i_pwdata;
        OFS_DEV_CTL:   hi_sel_q    <= i_pwdata[CTL_HISEL];
        default:       hi_sel_q    <= hi_sel_q;
      endcase
    end
  end

  // ==========================================================
  // Per-stream settings
  assign sel_d    = opt_q[OPT_SEL_HI:OPT_SEL_LO];
  assign eff_mult = (tl_mult_q != 8'h00) ? tl_mult_q :
                    (cfg_valid_q[sel_d] ? cfg_dflt_q[sel_d] : 8'h00);
  assign lim_en_d = (eff_mult != 8'h00);

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cfg_valid_q <= 8'h00;
      for (int i = 0; i < 8; i++) begin
        cfg_dflt_q[i] <= 8'h00;
        last_err_q[i] <= 48'h0;
      end
    end else begin
      if (wr && i_paddr == OFS_STRM_CFG) begin
        cfg_dflt_q[i_pwdata[CFG_SEL_HI:CFG_SEL_LO]]  <= i_pwdata[7:0];
        cfg_valid_q[i_pwdata[CFG_SEL_HI:CFG_SEL_LO]] <= 1'b1;
      end
      if (sec_err) begin
        last_err_q[cmd_opt_q[OPT_SEL_HI:OPT_SEL_LO]] <= lba_q;
      end
    end
  end

  // ==========================================================
  // Completion time limit
  assign active  = (state_q == ST_XFER) | (state_q == ST_FLUSH);
  assign timeout = active & lim_en_q & (elapsed_q >= lim_q);

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tick_q    <= '0;
      elapsed_q <= 40'h0;
      lim_q     <= 40'h0;
      lim_en_q  <= 1'b0;
    end else if (start) begin
      tick_q    <= '0;
      elapsed_q <= 40'h0;
      lim_q     <= calc_limit(eff_mult, time_unit_q);
      lim_en_q  <= lim_en_d;
    end else if (active) begin
      if (tick_q == TICK_W'(US_CYCLES - 1)) begin
        tick_q    <= '0;
        elapsed_q <= elapsed_q + 40'h1;
      end else begin
        tick_q <= tick_q + TICK_W'(1);
      end
    end
  end

  // ==========================================================
  // Command sequencing
  assign cont      = cmd_opt_q[OPT_CONT];
  assign sec_ev    = (state_q == ST_XFER) & i_sector_done & ~timeout;
  assign sec_err   = sec_ev & i_sector_err;
  assign fatal_err = sec_err & ~cont;

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q   <= ST_IDLE;
      lba_q     <= 48'h0;
      remain_q  <= 17'h0;
      dma_q     <= 1'b0;
      cmd_opt_q <= 8'h00;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start) begin
            state_q   <= ST_XFER;
            dma_q     <= (i_pwdata[7:0] == OPC_STREAM_DMA);
            cmd_opt_q <= opt_q;
            lba_q     <= opt_q[OPT_RESUME] ? last_err_q[sel_d]
                         : {addr_prev_q, addr_cur_q};
            remain_q  <= (count_q == 16'h0000) ? FULL_COUNT
                         : {1'b0, count_q};
          end
        end
        ST_XFER: begin
          if (timeout) begin
            state_q <= ST_END;
          end else if (fatal_err) begin
            state_q <= ST_END;
          end else if (sec_ev) begin
            lba_q    <= lba_q + 48'h1;
            remain_q <= remain_q - 17'h1;
            if (remain_q == 17'h1) begin
              state_q <= cmd_opt_q[OPT_FLUSH] ? ST_FLUSH : ST_END;
            end
          end
        end
        ST_FLUSH: begin
          if (timeout || i_flush_done) begin
            state_q <= ST_END;
          end
        end
        ST_END: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Ending status, failure cause and failing address
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cause_q    <= 8'h00;
      strm_err_q <= 1'b0;
      fail_q     <= 1'b0;
      err_seen_q <= 1'b0;
      fail_lba_q <= 48'h0;
    end else if (start) begin
      cause_q    <= 8'h00;
      strm_err_q <= 1'b0;
      fail_q     <= 1'b0;
      err_seen_q <= 1'b0;
    end else if (bad_cmd) begin
      cause_q    <= 8'h01 << ERR_ABORT;
      strm_err_q <= 1'b0;
      fail_q     <= 1'b1;
    end else if (timeout) begin
      cause_q[ERR_TLX] <= 1'b1;
      strm_err_q <= cont;
      fail_q     <= ~cont;
    end else if (sec_err) begin
      case (i_err_kind)
        KIND_CRC:  cause_q[ERR_CRC]   <= 1'b1;
        KIND_NOID: cause_q[ERR_NOID]  <= 1'b1;
        default:   cause_q[ERR_ABORT] <= 1'b1;
      endcase
      strm_err_q <= cont;
      fail_q     <= ~cont;
      err_seen_q <= 1'b1;
      if (!err_seen_q) begin
        fail_lba_q <= lba_q;
      end
    end
  end

  always_comb begin
    ending           = 8'h00;
    ending[STS_BUSY] = (state_q != ST_IDLE);
    ending[STS_RDY]  = (state_q == ST_IDLE);
    ending[STS_STREAM] = strm_err_q;
    ending[STS_DEFER]  = 1'b0;
    ending[STS_XREQ]   = (state_q == ST_XFER) & ~dma_q;
    ending[STS_FAIL] = fail_q;
  end

  // ==========================================================
  // Media side outputs
  assign o_sector_req       = (state_q == ST_XFER);
  assign o_sector_lba       = lba_q;
  assign o_dma_mode         = dma_q;
  assign o_urgent           = cmd_opt_q[OPT_URGENT];
  assign o_stream_sel       = cmd_opt_q[OPT_SEL_HI:OPT_SEL_LO];
  assign o_flush_req        = (state_q == ST_FLUSH);
  assign o_transfer_request = ending[STS_XREQ];
  assign o_busy             = ending[STS_BUSY];
  assign o_cmd_done         = (state_q == ST_END);

  // ==========================================================
  // Checks
  property p_start_pio;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    (start && i_pwdata[7:0] == OPC_STREAM_PIO) |=>
      (state_q == ST_XFER) && !dma_q && o_transfer_request;
  endproperty
  a_start_pio: assert property (p_start_pio)
    else $error("PIO streaming write did not start");

  property p_start_dma;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    (start && i_pwdata[7:0] == OPC_STREAM_DMA) |=>
      dma_q && o_busy && !o_transfer_request;
  endproperty
  a_start_dma: assert property (p_start_dma)
    else $error("DMA streaming write did not start");

  property p_count_zero;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    (start && count_q == 16'h0000) |=> (remain_q == FULL_COUNT);
  endproperty
  a_count_zero: assert property (p_count_zero)
    else $error("Zero count not taken as 65536");

  property p_lba;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    (start && !opt_q[OPT_RESUME]) |=>
      (lba_q == {$past(addr_prev_q), $past(addr_cur_q)});
  endproperty
  a_lba: assert property (p_lba)
    else $error("Start address assembled wrongly");

  property p_min_limit;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    (start && lim_en_d) |=> lim_en_q && (lim_q >= MIN_LIMIT_US);
  endproperty
  a_min_limit: assert property (p_min_limit)
    else $error("Time limit below minimum");

  property p_no_limit;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    (start && !lim_en_d) |=> !lim_en_q ##1 !timeout;
  endproperty
  a_no_limit: assert property (p_no_limit)
    else $error("Limit enforced without a usable value");

  property p_cont;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    (sec_err && cont && remain_q > 17'h1) |=>
      (state_q == ST_XFER) && strm_err_q;
  endproperty
  a_cont: assert property (p_cont)
    else $error("Command stopped on error in continue mode");

  property p_timeout_cont;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    (timeout && cont) |=> (state_q == ST_END) && o_cmd_done &&
      ending[STS_STREAM] && !ending[STS_FAIL] && cause_q[ERR_TLX]
      ##1 !o_busy;
  endproperty
  a_timeout_cont: assert property (p_timeout_cont)
    else $error("Timeout ending status wrong");

  property p_flush;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    (sec_ev && !fatal_err && remain_q == 17'h1 && cmd_opt_q[OPT_FLUSH]) |=>
      o_flush_req && !o_cmd_done;
  endproperty
  a_flush: assert property (p_flush)
    else $error("Completion reported before flush");

endmodule

// file: dv/swc_media_model.sv
/*
  Media engine model for the streaming write bench: answers sector and
  flush requests after a set gap, with errors on chosen sector indexes.
  Assumes requests are levels held by the command interpreter.
*/
`timescale 1ns/100ps

module swc_media_model (
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_b,
  input  wire logic       i_sector_req,
  input  wire logic       i_flush_req,
  input  wire logic [7:0] i_gap,
  input  wire logic [3:0] i_err_map,
  input  wire logic [1:0] i_err_kind,
  output logic            o_sector_done,
  output logic            o_sector_err,
  output logic      [1:0] o_err_kind,
  output logic            o_flush_done
);
  logic [7:0] cnt_q;
  logic [7:0] fcnt_q;
  logic [4:0] idx_q;

  // ==========================================
  // Sector answers; qualifiers churn between pulses
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_q         <= 8'h00;
      idx_q         <= 5'h00;
      o_sector_done <= 1'b0;
      o_sector_err  <= 1'b0;
      o_err_kind    <= 2'h0;
    end else begin
      o_sector_done <= 1'b0;
      o_sector_err  <= ~o_sector_err;
      o_err_kind    <= o_err_kind + 2'h1;
      if (!i_sector_req) begin
        cnt_q <= 8'h00;
        idx_q <= 5'h00;
      end else if (cnt_q == i_gap) begin
        cnt_q         <= 8'h00;
        idx_q         <= idx_q + 5'h01;
        o_sector_done <= 1'b1;
        o_sector_err  <= (idx_q < 5'h04) && i_err_map[idx_q[1:0]];
        o_err_kind    <= i_err_kind;
      end else begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end

  // ==========================================
  // Flush answer, one pulse per request
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      fcnt_q       <= 8'h00;
      o_flush_done <= 1'b0;
    end else begin
      o_flush_done <= i_flush_req && (fcnt_q == i_gap);
      if (!i_flush_req) begin
        fcnt_q <= 8'h00;
      end else if (fcnt_q != 8'hFF) begin
        fcnt_q <= fcnt_q + 8'h01;
      end
    end
  end
endmodule

// file: dv/tb_stream_write_command.sv
/*
  Self-checking bench for the streaming write command interpreter.
  Assumes swc_pkg, swc_stream_write and swc_media_model are compiled.
*/
`timescale 1ns/100ps

module tb_stream_write_command
  import swc_pkg::*;
;
  typedef struct {
    string       nm;
    logic [31:0] v;
  } swc_note_s;

  logic        clk;
  logic        rst_b;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sec_req;
  logic [47:0] sec_lba;
  logic        dma;
  logic        urgent;
  logic [2:0]  sel;
  logic        sec_done;
  logic        sec_err;
  logic [1:0]  kind;
  logic        fl_req;
  logic        fl_done;
  logic        xreq;
  logic        busy;
  logic        cmd_done;
  logic [7:0]  gap;
  logic [3:0]  err_map;
  logic [1:0]  err_kind;
  logic [31:0] rng;
  logic [31:0] cause_of [3] = '{32'h80, 32'h10, 32'h04};
  swc_note_s   notes[$];
  int          n_mismatch = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          t0;
  int          dur;
  int          n_flush = 0;
  int          f0;

  swc_stream_write #(.MIN_LIMIT_US(40'h2)) dut (
    .i_sys_clk(clk), .i_rst_b(rst_b), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .o_sector_req(sec_req),
    .o_sector_lba(sec_lba), .o_dma_mode(dma), .o_urgent(urgent),
    .o_stream_sel(sel), .i_sector_done(sec_done),
    .i_sector_err(sec_err), .i_err_kind(kind), .o_flush_req(fl_req),
    .i_flush_done(fl_done), .o_transfer_request(xreq), .o_busy(busy),
    .o_cmd_done(cmd_done));

  swc_media_model media (
    .i_sys_clk(clk), .i_rst_b(rst_b), .i_sector_req(sec_req),
    .i_flush_req(fl_req), .i_gap(gap), .i_err_map(err_map),
    .i_err_kind(err_kind), .o_sector_done(sec_done),
    .o_sector_err(sec_err), .o_err_kind(kind), .o_flush_done(fl_done));

  // ==========================================
  // Clock, cycle count, flush watch, read monitor
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (fl_done === 1'b1) n_flush <= n_flush + 1;
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      check(notes[0].nm, 48'(prdata), 48'(notes[0].v));
      void'(notes.pop_front());
    end
  end

  // ==========================================
  // Helpers
  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  function automatic logic [47:0] rnd_lba();
    logic [31:0] a;
    logic [31:0] b;
    a = xs();
    b = xs();
    return {a[23:0], b[23:0]};
  endfunction

  function automatic logic [47:0] near(input int d, input int l);
    return 48'(d > l - 5 && d < l + 5);
  endfunction

  task automatic check(input string nm, input logic [47:0] seen,
                       input logic [47:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, input logic err);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    check("pslverr", 48'(pslverr), 48'(err));
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 1'b0);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e,
                    input string nm);
    notes.push_back('{nm, e});
    xfer(1'b0, a, 32'h0, 1'b0);
  endtask

  task automatic start(input logic [7:0] opt, input logic [7:0] mult,
                       input logic [15:0] cnt, input logic [47:0] lba,
                       input logic [7:0] opc);
    wr(OFS_OPTIONS, {24'h0, opt});
    wr(OFS_TL_MULT, {24'h0, mult});
    wr(OFS_COUNT, {16'h0, cnt});
    wr(OFS_ADDR_CUR, {8'h0, lba[23:0]});
    wr(OFS_ADDR_PREV, {8'h0, lba[47:24]});
    f0 = n_flush;
    wr(OFS_COMMAND, {24'h0, opc});
    t0 = cyc;
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    while (cmd_done !== 1'b1 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    check("cmd_done", 48'(cmd_done), 48'h1);
    dur = cyc - t0;
    @(posedge clk);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    wrap_up();
  end

  // ==========================================
  // Tests
  initial begin
    logic [47:0] lba;
    logic [2:0]  s;
    rst_b    = 1'b0;
    psel     = 1'b0;
    penable  = 1'b0;
    pwrite   = 1'b0;
    paddr    = 12'h000;
    pwdata   = 32'h0;
    gap      = 8'h04;
    err_map  = 4'h0;
    err_kind = 2'h0;
    rng      = 32'h38;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(OFS_ENDING, 32'h40, "ending");
    rd(OFS_TIME_UNIT, 32'h1, "time unit");
    xfer(1'b1, 12'h030, 32'h0, 1'b1);
    $display("test reset ended");
    for (int i = 0; i < 2; i++) begin
      lba = rnd_lba();
      s = 3'(xs());
      start({i[0], 4'h0, s}, 8'h00, 16'(3'(xs()) + 1), lba,
            i ? OPC_STREAM_DMA : OPC_STREAM_PIO);
      check("lba", sec_lba, lba);
      check("dma", 48'(dma), 48'(i));
      check("xfer req", 48'(xreq), 48'(i == 0));
      check("urgent", 48'(urgent), 48'(i));
      check("sel", 48'(sel), 48'(s));
      check("busy", 48'(busy), 48'h1);
      check("sector req", 48'(sec_req), 48'h1);
      wait_done();
      rd(OFS_ENDING, 32'h40, "ending");
      rd(OFS_CAUSE, 32'h0, "cause");
      rd(OFS_REMAIN, 32'h0, "remain");
    end
    $display("test opcodes ended");
    lba = rnd_lba();
    err_map <= 4'h2;
    err_kind <= KIND_NOID;
    start(8'h03, 8'h00, 16'h3, lba, OPC_STREAM_PIO);
    wait_done();
    lba = lba + 48'h1;
    rd(OFS_ENDING, 32'h41, "ending");
    rd(OFS_CAUSE, 32'h10, "cause");
    rd(OFS_ADDR_CUR, {8'h0, lba[23:0]}, "fail low");
    wr(OFS_DEV_CTL, 32'h80);
    rd(OFS_ADDR_CUR, {8'h0, lba[47:24]}, "fail high");
    wr(OFS_DEV_CTL, 32'h0);
    err_map <= 4'h0;
    start(8'h13, 8'h00, 16'h3, rnd_lba(), OPC_STREAM_PIO);
    check("resume lba", sec_lba, lba);
    xfer(1'b1, OFS_COMMAND, 32'h3B, 1'b1);
    wait_done();
    $display("test abort and resume ended");
    err_map <= 4'h5;
    for (int k = 0; k < 3; k++) begin
      err_kind <= 2'(k);
      start(8'h41, 8'h00, 16'h4, rnd_lba(), OPC_STREAM_PIO);
      wait_done();
      rd(OFS_ENDING, 32'h60, "ending");
      rd(OFS_CAUSE, cause_of[k], "cause");
      rd(OFS_REMAIN, 32'h0, "remain");
    end
    err_map <= 4'h0;
    $display("test continue ended");
    gap <= 8'h14;
    wr(OFS_TIME_UNIT, 32'h2);
    start(8'h42, 8'h02, 16'h0, rnd_lba(), OPC_STREAM_PIO);
    rd(OFS_REMAIN, 32'h10000, "remain");
    wait_done();
    check("limit", near(dur, 400), 48'h1);
    rd(OFS_ENDING, 32'h60, "ending");
    rd(OFS_CAUSE, 32'h01, "cause");
    wr(OFS_TIME_UNIT, 32'h1);
    start(8'h02, 8'h01, 16'h0, rnd_lba(), OPC_STREAM_PIO);
    wait_done();
    check("clamp", near(dur, 200), 48'h1);
    rd(OFS_ENDING, 32'h41, "ending");
    rd(OFS_CAUSE, 32'h01, "cause");
    wr(OFS_STRM_CFG, 32'h503);
    wr(OFS_STRM_CFG, 32'h400);
    start(8'h05, 8'h00, 16'h0, rnd_lba(), OPC_STREAM_PIO);
    check("sel", 48'(sel), 48'h5);
    wait_done();
    check("default", near(dur, 300), 48'h1);
    $display("test time limit ended");
    gap <= 8'hFA;
    for (int k = 4; k < 7; k += 2) begin
      start(8'(k), 8'h00, 16'h2, rnd_lba(), OPC_STREAM_PIO);
      wait_done();
      rd(OFS_ENDING, 32'h40, "ending");
    end
    gap <= 8'h1E;
    start(8'h21, 8'h00, 16'h1, rnd_lba(), OPC_STREAM_DMA);
    wait_done();
    check("flushed", 48'(n_flush - f0), 48'h1);
    wr(OFS_COMMAND, 32'hFF);
    rd(OFS_ENDING, 32'h41, "ending");
    rd(OFS_CAUSE, 32'h04, "cause");
    $display("test flush and opcode ended");
    wrap_up();
  end
endmodule
